/* rtl/mdah_pkg.sv */
// Operation
// - any alarm drops status output; all but abnormal data halt motor
// - abnormal data alarm keeps motor current on
// - code mode remaps ready/torque/timing to code bits
// - code reporting setting 0/1, resets to 0
// - alarm LED blinks count identifying the alarm
// - overvoltage alarm blinks three times per group
// - fault clear acts on ON-to-OFF edge only
// - tool command or power cycle clears alarm
// - non-resettable alarms clear only by power cycle
// - warning asserted before alarm threshold reached
// - overheat alarm: two blinks, code 21, bit1
// - overvoltage alarm code 22, non-resettable
// - command pulse above 500 kHz raises code 34
package mdah_pkg;
	typedef enum logic [2:0] {
		ALM_NONE, ALM_OVERHEAT, ALM_OVERVOLT, ALM_CMD_PULSE, ALM_ABN_DATA
	} mdah_alarm_e;

	typedef enum logic [1:0] {LED_IDLE, LED_ON, LED_OFF, LED_GAP} mdah_led_e;

	// per-alarm presentation and handling
	typedef struct packed {
		logic [6:0] code;
		logic [2:0] bits;
		logic [3:0] blinks;
		logic resettable;
		logic keep_motor;
	} mdah_info_s;

	// outputs that double as fault code bits
	typedef struct packed {
		logic timing;
		logic torque_limit;
		logic ready;
	} mdah_gen_s;

	localparam logic [6:0] OVERHEAT_CODE = 7'h15;
	localparam logic [6:0] OVERVOLT_CODE = 7'h16;
	localparam logic [6:0] CMD_PULSE_CODE = 7'h22;
	localparam logic [6:0] ABN_DATA_CODE = 7'h4D;
	localparam logic [2:0] OVERHEAT_BITS = 3'h2;
	localparam logic [2:0] OVERVOLT_BITS = 3'h3;
	localparam logic [2:0] CMD_PULSE_BITS = 3'h2;
	localparam logic [2:0] ABN_DATA_BITS = 3'h7;
	localparam logic [3:0] OVERHEAT_BLINKS = 4'h2;
	localparam logic [3:0] OVERVOLT_BLINKS = 4'h3;
	localparam logic [3:0] CMD_PULSE_BLINKS = 4'h2;
	localparam logic [3:0] ABN_DATA_BLINKS = 4'h7;
	localparam logic CODE_EN_RESET = 1'b0;
	localparam logic [3:0] LED_GAP_TICKS = 4'h6;

	// timing
	localparam int CLK_KHZ = 125000;
	localparam int CMD_PULSE_MAX_KHZ = 500;
	localparam int CMD_MIN_CYCLES =
		(CLK_KHZ + CMD_PULSE_MAX_KHZ - 1) / CMD_PULSE_MAX_KHZ;
	localparam int LED_HALF_MS = 200;
	localparam int LED_TICK_CYCLES = LED_HALF_MS * CLK_KHZ;
endpackage

/* rtl/mdah_alarm_handler.sv */
`timescale 1ns/1ps
`default_nettype none
module mdah_alarm_handler
	import mdah_pkg::*;
#(
	parameter logic [7:0] TEMP_WARN = 8'hB0,
	parameter logic [7:0] TEMP_ALARM = 8'hC0,
	parameter logic [7:0] VOLT_WARN = 8'hD0,
	parameter logic [7:0] VOLT_ALARM = 8'hE0,
	parameter int LED_TICKS = LED_TICK_CYCLES
)
(
	// clock and reset
	input wire logic clk_i,
	input wire logic reset_i,
	// monitored conditions
	input wire logic [7:0] temp_i,
	input wire logic [7:0] volt_i,
	input wire logic cmd_pulse_i,
	input wire logic abn_data_i,
	// alarm clearing
	input wire logic fault_clear_in_i,
	input wire logic tool_reset_i,
	// code reporting setting
	input wire logic cfg_write_i,
	input wire logic cfg_code_en_i,
	// normal general outputs
	input wire mdah_gen_s gen_norm_i,
	// driver outputs
	output logic alarm_status_out_o,
	output logic excite_o,
	output logic motion_enable_o,
	output logic warning_o,
	output logic alarm_led_o,
	output mdah_gen_s gen_out_o,
	output logic [6:0] alarm_code_o
);
	function automatic mdah_info_s info_of(input mdah_alarm_e k);
		mdah_info_s r;
		r = '{7'h00, 3'h0, 4'h0, 1'b1, 1'b1};
		case (k)
			ALM_OVERHEAT:
				r = '{OVERHEAT_CODE, OVERHEAT_BITS, OVERHEAT_BLINKS,
					1'b1, 1'b0};
			ALM_OVERVOLT:
				r = '{OVERVOLT_CODE, OVERVOLT_BITS, OVERVOLT_BLINKS,
					1'b0, 1'b0};
			ALM_CMD_PULSE:
				r = '{CMD_PULSE_CODE, CMD_PULSE_BITS, CMD_PULSE_BLINKS,
					1'b1, 1'b0};
			ALM_ABN_DATA:
				r = '{ABN_DATA_CODE, ABN_DATA_BITS, ABN_DATA_BLINKS,
					1'b1, 1'b1};
			default:
				r = '{7'h00, 3'h0, 4'h0, 1'b1, 1'b1};
		endcase
		return r;
	endfunction

	// clear class of an alarm, for override decisions
	function automatic logic clears_of(input mdah_alarm_e k);
		mdah_info_s r;
		r = info_of(k);
		return r.resettable;
	endfunction

	mdah_alarm_e alarm;
	mdah_alarm_e next_alarm;
	mdah_alarm_e raise;
	mdah_info_s cur;
	logic code_en;
	logic clear_prev;
	logic fault_fall;
	logic pulse_prev;
	logic pulse_seen;
	logic [8:0] pulse_gap;
	logic too_fast;
	mdah_led_e led_state;
	logic [31:0] div_cnt;
	logic tick;
	logic [3:0] blink_cnt;
	logic [3:0] rise_cnt;

	assign cur = info_of(alarm);
	assign fault_fall = clear_prev && !fault_clear_in_i;

	// setting is written by the tool, survives until power cycle
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
			code_en <= CODE_EN_RESET;
		else if (cfg_write_i)
			code_en <= cfg_code_en_i;
	end

	// edge history of the clear input and command pulse
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			clear_prev <= 1'b0;
			pulse_prev <= 1'b0;
		end
		else
		begin
			clear_prev <= fault_clear_in_i;
			pulse_prev <= cmd_pulse_i;
		end
	end

	// period between rising edges; shorter than the limit is too fast
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			pulse_gap <= 9'h000;
			pulse_seen <= 1'b0;
			too_fast <= 1'b0;
		end
		else
		begin
			too_fast <= 1'b0;
			if (cmd_pulse_i && !pulse_prev)
			begin
				too_fast <= pulse_seen &&
					(pulse_gap < 9'(CMD_MIN_CYCLES - 1));
				pulse_seen <= 1'b1;
				pulse_gap <= 9'h000;
			end
			else if (pulse_gap != 9'(CMD_MIN_CYCLES))
				pulse_gap <= pulse_gap + 9'h001;
		end
	end

	// new condition; overvoltage first since it cannot be cleared
	always_comb
	begin
		raise = ALM_NONE;
		if (volt_i >= VOLT_ALARM)
			raise = ALM_OVERVOLT;
		else if (temp_i >= TEMP_ALARM)
			raise = ALM_OVERHEAT;
		else if (too_fast)
			raise = ALM_CMD_PULSE;
		else if (abn_data_i)
			raise = ALM_ABN_DATA;
	end

	// a condition still present at the clear re-raises at once
	always_comb
	begin
		next_alarm = alarm;
		if ((fault_fall || tool_reset_i) && cur.resettable)
			next_alarm = ALM_NONE;
		if (raise != ALM_NONE && (next_alarm == ALM_NONE ||
			(!clears_of(raise) && clears_of(next_alarm))))
			next_alarm = raise;
	end

	// power cycle clears every alarm and is the only clear for overvoltage
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
			alarm <= ALM_NONE;
		else
			alarm <= next_alarm;
	end

	// motor and status outputs follow the latched alarm
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			alarm_status_out_o <= 1'b1;
			excite_o <= 1'b1;
			motion_enable_o <= 1'b1;
			alarm_code_o <= 7'h00;
		end
		else
		begin
			alarm_status_out_o <= (alarm == ALM_NONE);
			excite_o <= cur.keep_motor;
			motion_enable_o <= cur.keep_motor;
			alarm_code_o <= cur.code;
		end
	end

	// warning below the alarm threshold
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
			warning_o <= 1'b0;
		else
			warning_o <= (temp_i >= TEMP_WARN) ||
				(volt_i >= VOLT_WARN);
	end

	// general outputs carry code bits only while an alarm stands
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
			gen_out_o <= '0;
		else if (code_en && alarm != ALM_NONE)
			gen_out_o <= cur.bits;
		else
			gen_out_o <= gen_norm_i;
	end

	// half-period divider, restarted whenever the LED is idle
	always_ff @(posedge clk_i)
	begin
		if (reset_i || led_state == LED_IDLE)
		begin
			div_cnt <= 32'h00000000;
			tick <= 1'b0;
		end
		else
		begin
			tick <= (div_cnt == 32'(LED_TICKS - 2));
			if (div_cnt == 32'(LED_TICKS - 1))
				div_cnt <= 32'h00000000;
			else
				div_cnt <= div_cnt + 32'h00000001;
		end
	end

	// blink groups; code read live so an override applies to the current group
	always_ff @(posedge clk_i)
	begin
		if (reset_i || alarm == ALM_NONE)
		begin
			led_state <= LED_IDLE;
			blink_cnt <= 4'h0;
			alarm_led_o <= 1'b0;
		end
		else
		begin
			case (led_state)
				LED_IDLE:
				begin
					led_state <= LED_ON;
					blink_cnt <= 4'h1;
					alarm_led_o <= 1'b1;
				end
				LED_ON:
					if (tick)
					begin
						led_state <= LED_OFF;
						alarm_led_o <= 1'b0;
					end
				LED_OFF:
					if (tick && blink_cnt >= cur.blinks)
					begin
						led_state <= LED_GAP;
						blink_cnt <= 4'h0;
					end
					else if (tick)
					begin
						led_state <= LED_ON;
						blink_cnt <= blink_cnt + 4'h1;
						alarm_led_o <= 1'b1;
					end
				LED_GAP:
					if (tick && blink_cnt == LED_GAP_TICKS - 4'h1)
					begin
						led_state <= LED_ON;
						blink_cnt <= 4'h1;
						alarm_led_o <= 1'b1;
					end
					else if (tick)
						blink_cnt <= blink_cnt + 4'h1;
				default:
					led_state <= LED_IDLE;
			endcase
		end
	end

	// helper: LED rises after the first counted per group, for checking only
	always_ff @(posedge clk_i)
	begin
		if (reset_i || led_state == LED_GAP || led_state == LED_IDLE)
			rise_cnt <= 4'h0;
		else if (led_state == LED_OFF && tick && blink_cnt < cur.blinks)
			rise_cnt <= rise_cnt + 4'h1;
	end

	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);

	status_off_a: assert property (alarm != ALM_NONE |=>
		!alarm_status_out_o) else $error("status on during alarm");
	motor_halt_a: assert property (alarm != ALM_NONE &&
		alarm != ALM_ABN_DATA |=> !excite_o && !motion_enable_o)
		else $error("motor not halted");
	abn_keeps_a: assert property (alarm == ALM_ABN_DATA |=>
		excite_o ##0 motion_enable_o) else $error("abn data stopped motor");
	code_bits_a: assert property (code_en && alarm != ALM_NONE |=>
		gen_out_o == $past(cur.bits)) else $error("code bits wrong");
	code_default_a: assert property ($past(reset_i) |->
		!code_en) else $error("code enable not cleared");
	blink_group_a: assert property (led_state == LED_OFF && tick &&
		blink_cnt >= cur.blinks |-> rise_cnt + 4'h1 == cur.blinks)
		else $error("blink count mismatch");
	overvolt_blink_a: assert property (alarm == ALM_OVERVOLT &&
		led_state == LED_OFF && tick |-> cur.blinks == 4'h3 &&
		blink_cnt <= 4'h3) else $error("overvoltage blink count");
	rise_noclear_a: assert property ($rose(fault_clear_in_i) &&
		alarm == ALM_OVERHEAT && !tool_reset_i |=> alarm != ALM_NONE)
		else $error("cleared on rising edge");
	tool_clear_a: assert property (tool_reset_i &&
		alarm == ALM_CMD_PULSE && raise == ALM_NONE |=>
		alarm == ALM_NONE) else $error("tool reset ignored");
	overvolt_hold_a: assert property (alarm == ALM_OVERVOLT |=>
		alarm == ALM_OVERVOLT [*2]) else $error("overvoltage cleared");
	warn_early_a: assert property (temp_i >= TEMP_WARN |=>
		warning_o) else $error("warning missing");
	overheat_raise_a: assert property (temp_i >= TEMP_ALARM &&
		volt_i < VOLT_ALARM && alarm == ALM_NONE |=>
		alarm == ALM_OVERHEAT ##2 alarm_code_o == 7'h15)
		else $error("overheat not raised");
	overvolt_raise_a: assert property (volt_i >= VOLT_ALARM |=>
		alarm == ALM_OVERVOLT ##1 !excite_o) else $error("overvoltage missed");
	pulse_raise_a: assert property (too_fast &&
		raise == ALM_CMD_PULSE && alarm == ALM_NONE |=>
		alarm == ALM_CMD_PULSE) else $error("pulse alarm missed");
	restore_a: assert property ($fell(alarm != ALM_NONE) |=>
		alarm_status_out_o && !alarm_led_o) else $error("not restored");

	overheat_cov_c: cover property (alarm == ALM_OVERHEAT ##1
		fault_fall ##1 alarm == ALM_NONE);
	overvolt_cov_c: cover property (alarm == ALM_OVERVOLT &&
		led_state == LED_GAP);
	code_cov_c: cover property (code_en && alarm == ALM_CMD_PULSE);
endmodule
`default_nettype wire

/* tb/mdah_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module mdah_host_model (
	// clock
	input wire logic clk_i,
	// requests from the bench
	input wire logic clr_req_i,
	input wire logic [9:0] period_i,
	// lines into the driver
	output logic fault_clear_o,
	output logic cmd_pulse_o
);
	logic [2:0] hold = 3'h0;
	logic [9:0] pcnt = 10'h000;

	// clear line held ON a few cycles; only its release clears
	always_ff @(posedge clk_i)
	begin
		if (clr_req_i)
			hold <= 3'h4;
		else if (hold != 3'h0)
			hold <= hold - 3'h1;
		fault_clear_o <= clr_req_i || hold > 3'h1;
	end

	// pulse train stands still while the period is zero
	always_ff @(posedge clk_i)
	begin
		if (period_i == 10'h000 || pcnt >= period_i - 10'h001)
			pcnt <= 10'h000;
		else
			pcnt <= pcnt + 10'h001;
		cmd_pulse_o <= period_i != 10'h000 && pcnt == 10'h000;
	end
endmodule
`default_nettype wire

/* tb/mdah_alarm_handler_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(w, e, g) begin checks++; if ((g) !== (e)) begin fail_count++; \
$display("FAIL %s exp %0h got %0h", w, e, g); end end
module mdah_alarm_handler_bench
	import mdah_pkg::*;
;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic [7:0] temp = 8'h00;
	logic [7:0] volt = 8'h00;
	logic abn = 1'b0;
	logic tool = 1'b0;
	logic cfg_wr = 1'b0;
	logic cfg_en = 1'b0;
	logic clr_req = 1'b0;
	logic [9:0] period = 10'h000;
	mdah_gen_s gen_norm = 3'h5;
	mdah_gen_s gen_out;
	logic [6:0] code;
	logic fclr, pulse, status, excite, motion, warn, led;
	int fail_count = 0;
	int checks = 0;
	int n;

	// short LED tick keeps blink groups within a few hundred cycles
	mdah_alarm_handler #(.LED_TICKS(8)) dut (.clk_i(clk), .reset_i(reset),
		.temp_i(temp), .volt_i(volt), .cmd_pulse_i(pulse),
		.abn_data_i(abn), .fault_clear_in_i(fclr), .tool_reset_i(tool),
		.cfg_write_i(cfg_wr), .cfg_code_en_i(cfg_en), .gen_norm_i(gen_norm),
		.alarm_status_out_o(status), .excite_o(excite),
		.motion_enable_o(motion), .warning_o(warn), .alarm_led_o(led),
		.gen_out_o(gen_out), .alarm_code_o(code));
	mdah_host_model host (.clk_i(clk), .clr_req_i(clr_req),
		.period_i(period), .fault_clear_o(fclr), .cmd_pulse_o(pulse));

	always #4 clk = ~clk;

	// wait edges, then sample at the settled falling edge
	task automatic wt(input int k);
		repeat (k) @(posedge clk);
		@(negedge clk);
	endtask

	// counts LED turn-ons, one already lit included
	task automatic blinks(input int k, output int c);
		logic p;
		p = 1'b0;
		c = 0;
		repeat (k)
		begin
			if (led && !p)
				c++;
			p = led;
			@(negedge clk);
		end
	endtask

	// host clear: status must hold while the line is still ON
	task automatic host_clear();
		@(posedge clk) clr_req <= 1'b1;
		@(posedge clk) clr_req <= 1'b0;
		wt(2);
		`CHK("clr on", 1'b0, status)
		wt(6);
	endtask

	task automatic tool_pulse();
		@(posedge clk) tool <= 1'b1;
		@(posedge clk) tool <= 1'b0;
		wt(3);
	endtask

	task automatic t_heat();
		`CHK("idle", 1'b1, status)
		@(posedge clk) temp <= 8'hB0;
		wt(3);
		`CHK("warn", 1'b1, warn)
		`CHK("pre", 1'b1, status)
		@(posedge clk) temp <= 8'hC0;
		wt(3);
		`CHK("status", 1'b0, status)
		`CHK("motion", 1'b0, motion)
		`CHK("excite", 1'b0, excite)
		`CHK("code", 7'h15, code)
		`CHK("gen", 3'h5, gen_out)
		blinks(72, n);
		`CHK("blinks", 2, n)
		@(posedge clk) temp <= 8'h00;
		host_clear();
		`CHK("st", 1'b1, status)
		`CHK("ex", 1'b1, excite)
		`CHK("led", 1'b0, led)
		$display("done heat");
	endtask

	task automatic t_code();
		@(posedge clk)
		begin
			cfg_wr <= 1'b1;
			cfg_en <= 1'b1;
		end
		@(posedge clk) cfg_wr <= 1'b0;
		@(posedge clk) temp <= 8'hC0;
		wt(3);
		`CHK("bits", 3'h2, gen_out)
		@(posedge clk) temp <= 8'h00;
		tool_pulse();
		`CHK("tool", 1'b1, status)
		`CHK("gen", 3'h5, gen_out)
		$display("done code");
	endtask

	task automatic t_volt();
		@(posedge clk) volt <= 8'hE0;
		wt(3);
		`CHK("code", 7'h16, code)
		`CHK("bits", 3'h3, gen_out)
		blinks(72, n);
		`CHK("blinks", 3, n)
		@(posedge clk) volt <= 8'h00;
		host_clear();
		tool_pulse();
		`CHK("held", 1'b0, status)
		`CHK("hcode", 7'h16, code)
		@(posedge clk) reset <= 1'b1;
		@(posedge clk) reset <= 1'b0;
		wt(2);
		`CHK("pwr", 1'b1, status)
		`CHK("pcode", 7'h00, code)
		$display("done volt");
	endtask

	task automatic t_pulse();
		@(posedge clk) period <= 10'd250; // exactly at the limit
		wt(800);
		`CHK("slow", 1'b1, status)
		@(posedge clk) period <= 10'd100;
		wt(300);
		`CHK("code", 7'h22, code)
		`CHK("excite", 1'b0, excite)
		@(posedge clk) period <= 10'h000;
		wt(4); // a pulse in flight would re-raise at the clear
		tool_pulse();
		`CHK("clr", 1'b1, status)
		$display("done pulse");
	endtask

	task automatic t_abn();
		@(posedge clk) abn <= 1'b1;
		wt(3);
		`CHK("status", 1'b0, status)
		`CHK("excite", 1'b1, excite)
		`CHK("code", 7'h4D, code)
		@(posedge clk) abn <= 1'b0;
		host_clear();
		`CHK("clr", 1'b1, status)
		$display("done abn");
	endtask

	task automatic stop_test();
		$display("checks %0d fails %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// all tests need about 1,350 cycles
	initial
	begin
		repeat (20000) @(posedge clk);
		fail_count++;
		stop_test();
	end

	initial
	begin
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		wt(2);
		t_heat();
		t_code();
		t_volt();
		t_pulse();
		t_abn();
		stop_test();
	end
endmodule
`default_nettype wire
